// File: src/ihpi_host_pins.sv
`timescale 1ns/1ns
// Behaviour
// - Three-bit host index selects which indirect register port an access reaches.
// - Sixteen-bit two-way host data bus, released while reset is held.
// - Active-low host chip select qualifies every host register access.
// - Read pin is read enable with strap 0, data strobe with strap 1.
// - Write pin is write enable with strap 0, read/write direction with strap 1.
// - Interrupt output rises on internal event, falls on host clear, low in reset.
// - Reset returns all state to defaults and all outputs to inactive levels, except the pull enables, which reset on.
// - Frame sync appears on host sync output as sync configuration dictates.
// - In bypass, bypass chip select passes to first or second panel select.
// - Bypass chip select pull-up follows the bypass pull control bit.
// - In serial bypass with second panel selected, host serial clock passes to second panel.
// - In bypass with second panel selected, command select input passes through to second panel.
// - Pull-downs on serial clock and command select enabled for parallel host.
// - Those pull-downs follow the same bypass pull control bit.
// - In serial bypass with second panel selected, host serial data passes to second panel.
// - In parallel bypass, host write strobe drives the panel frame pin.
// - In parallel bypass, bypass command select drives the panel line pin.
// - In parallel bypass, host data crosses the panel data pins both ways.
module ihpi_host_pins (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [2:0]            host_port_index,
	input  wire logic                  host_cs_n,
	input  wire logic                  host_rd_pin,
	input  wire logic                  host_wr_pin,
	input  wire logic                  bus_style_strap,
	input  wire logic [15:0]           host_data_bus_i,
	output logic      [15:0]           host_data_bus_o,
	output logic                       host_data_bus_oe,
	output logic                       host_irq,
	output logic                       host_sync_out,
	input  wire logic                  bypass_chip_select_n,
	input  wire logic                  bypass_sck,
	input  wire logic                  bypass_sdi,
	input  wire logic                  bypass_cmd_select,
	output logic                       bypass_cs_pullup_en,
	output logic                       bypass_pulldown_en,
	input  wire logic [15:0]           misc_cfg,
	input  wire logic [15:0]           sync_cfg,
	input  wire ihpi_pkg::ihpi_bypass_t bypass_mode,
	input  wire logic                  irq_event,
	input  wire logic                  irq_clear,
	input  wire logic                  frame_sync,
	output logic      [2:0]            reg_index,
	output logic                       reg_wr_pulse,
	output logic      [15:0]           reg_wr_data,
	output logic                       reg_rd_pulse,
	input  wire logic [15:0]           reg_rd_data,
	input  wire logic                  normal_frame,
	input  wire logic                  normal_line,
	input  wire logic [15:0]           normal_pdata,
	output logic                       panel_frame_pin,
	output logic                       panel_line_pin,
	input  wire logic [15:0]           panel_data_pins_i,
	output logic      [15:0]           panel_data_pins_o,
	output logic                       panel_data_pins_oe,
	output logic                       first_panel_cs_n,
	output logic                       second_panel_cs_n,
	output logic                       second_panel_sck,
	output logic                       second_panel_sdo,
	output logic                       second_panel_cmd
);

	ihpi_pkg::ihpi_pins_t  raw;
	ihpi_pkg::ihpi_pins_t  p;
	ihpi_pkg::ihpi_state_t st_ff;
	ihpi_pkg::ihpi_state_t nxt_st;
	logic                  strap_ff;
	logic                  strap_taken_ff;
	logic [2:0]            strap_wait_ff;
	logic                  rd_req;
	logic                  wr_req;
	logic                  par_byp;
	logic                  ser_byp;
	logic                  byp_rd;
	logic                  byp_rd_ff;
	logic [2:0]            reg_index_ff;
	logic                  reg_wr_pulse_ff;
	logic [15:0]           reg_wr_data_ff;
	logic                  reg_rd_pulse_ff;
	logic [15:0]           hdata_o_ff;
	logic                  irq_ff;
	logic                  sync_out_ff;
	logic                  pullup_ff;
	logic                  pulldown_ff;
	logic                  frame_ff;
	logic                  line_ff;
	logic [15:0]           pdata_o_ff;
	logic                  first_cs_n_ff;
	logic                  second_cs_n_ff;
	logic                  sck_ff;
	logic                  sdo_ff;
	logic                  cmd_ff;

	function automatic logic style_rd(input logic style, input logic rd, input logic wr);
		return (style == ihpi_pkg::IHPI_STYLE_80) ? ~rd : (~rd & wr);
	endfunction
	function automatic logic style_wr(input logic style, input logic rd, input logic wr);
		return (style == ihpi_pkg::IHPI_STYLE_80) ? ~wr : (~rd & ~wr);
	endfunction

	assign raw = '{cs_n: host_cs_n, rd_pin: host_rd_pin, wr_pin: host_wr_pin,
		index: host_port_index, strap: bus_style_strap, byp_cs_n: bypass_chip_select_n,
		byp_sck: bypass_sck, byp_sdi: bypass_sdi, byp_cmd: bypass_cmd_select,
		hdata: host_data_bus_i, pdata: panel_data_pins_i};

	ihpi_pin_sync #(
		.W       (ihpi_pkg::IHPI_PINS_W),
		.RST_VAL (ihpi_pkg::IHPI_PINS_RST)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (raw),
		.q_ff  (p)
	);

	// Strap is taken once the synchroniser has flushed its reset value, not at release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strap_ff       <= ihpi_pkg::IHPI_STYLE_80;
			strap_taken_ff <= 1'b0;
			strap_wait_ff  <= 3'h0;
		end else if (!strap_taken_ff) begin
			strap_wait_ff <= strap_wait_ff + 3'h1;
			if (strap_wait_ff == 3'(ihpi_pkg::IHPI_STRAP_WAIT)) begin
				strap_ff       <= p.strap;
				strap_taken_ff <= 1'b1;
			end
		end
	end

	assign rd_req  = strap_taken_ff & ~p.cs_n & style_rd(strap_ff, p.rd_pin, p.wr_pin);
	assign wr_req  = strap_taken_ff & ~p.cs_n & style_wr(strap_ff, p.rd_pin, p.wr_pin);
	assign par_byp = bypass_mode.enable & ~bypass_mode.serial;
	assign ser_byp = bypass_mode.enable & bypass_mode.serial & bypass_mode.second;
	assign byp_rd  = par_byp & ~p.byp_cs_n & style_rd(strap_ff, p.rd_pin, p.wr_pin);

	// Read wins if a 80-style host ever asserts both strobes at once
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			ihpi_pkg::IHPI_IDLE: begin
				if (rd_req) begin
					nxt_st = ihpi_pkg::IHPI_READ;
				end else if (wr_req) begin
					nxt_st = ihpi_pkg::IHPI_WRITE;
				end
			end
			ihpi_pkg::IHPI_READ: begin
				if (!rd_req) begin
					nxt_st = ihpi_pkg::IHPI_IDLE;
				end
			end
			ihpi_pkg::IHPI_WRITE: begin
				if (!wr_req) begin
					nxt_st = ihpi_pkg::IHPI_IDLE;
				end
			end
			default: begin
				nxt_st = ihpi_pkg::IHPI_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= ihpi_pkg::IHPI_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Port index is latched at the start of an access and held until the next one
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_index_ff <= ihpi_pkg::IHPI_INDEX_RST;
		end else if (st_ff == ihpi_pkg::IHPI_IDLE && (rd_req || wr_req)) begin
			reg_index_ff <= p.index;
		end
	end

	// Write data commits at strobe release, so the host's final bus value is the one used
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_wr_data_ff  <= ihpi_pkg::IHPI_DATA_RST;
			reg_wr_pulse_ff <= 1'b0;
			reg_rd_pulse_ff <= 1'b0;
		end else begin
			if (st_ff == ihpi_pkg::IHPI_WRITE && wr_req) begin
				reg_wr_data_ff <= p.hdata;
			end
			reg_wr_pulse_ff <= (st_ff == ihpi_pkg::IHPI_WRITE) && !wr_req;
			reg_rd_pulse_ff <= (st_ff == ihpi_pkg::IHPI_IDLE) && rd_req;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hdata_o_ff <= ihpi_pkg::IHPI_DATA_RST;
			byp_rd_ff  <= 1'b0;
		end else begin
			byp_rd_ff  <= byp_rd;
			hdata_o_ff <= (nxt_st == ihpi_pkg::IHPI_READ) ? reg_rd_data : p.pdata;
		end
	end

	// Bus released in reset and whenever no selected read is running
	assign host_data_bus_oe = rst_n & ((st_ff == ihpi_pkg::IHPI_READ) | byp_rd_ff);

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (irq_event) begin
			irq_ff <= 1'b1;
		end else if (irq_clear) begin
			irq_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_out_ff <= 1'b0;
		end else begin
			sync_out_ff <= sync_cfg[ihpi_pkg::IHPI_SYNC_EN_BIT] &
				(frame_sync ^ sync_cfg[ihpi_pkg::IHPI_SYNC_INV_BIT]);
		end
	end

	// Pulls default on so floating bypass pins stay defined through reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pullup_ff   <= ihpi_pkg::IHPI_PULL_RST;
			pulldown_ff <= ihpi_pkg::IHPI_PULL_RST;
		end else begin
			pullup_ff   <= misc_cfg[ihpi_pkg::IHPI_PULL_CTRL_BIT];
			pulldown_ff <= misc_cfg[ihpi_pkg::IHPI_PULL_CTRL_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_ff   <= 1'b0;
			line_ff    <= 1'b0;
			pdata_o_ff <= ihpi_pkg::IHPI_DATA_RST;
		end else begin
			frame_ff   <= par_byp ? p.wr_pin : normal_frame;
			line_ff    <= par_byp ? p.byp_cmd : normal_line;
			pdata_o_ff <= par_byp ? p.hdata : normal_pdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			first_cs_n_ff  <= ihpi_pkg::IHPI_CS_OFF;
			second_cs_n_ff <= ihpi_pkg::IHPI_CS_OFF;
			sck_ff         <= 1'b0;
			sdo_ff         <= 1'b0;
			cmd_ff         <= 1'b0;
		end else begin
			first_cs_n_ff  <= (bypass_mode.enable && !bypass_mode.second) ?
				p.byp_cs_n : ihpi_pkg::IHPI_CS_OFF;
			second_cs_n_ff <= (bypass_mode.enable && bypass_mode.second) ?
				p.byp_cs_n : ihpi_pkg::IHPI_CS_OFF;
			sck_ff         <= ser_byp & p.byp_sck;
			sdo_ff         <= ser_byp & p.byp_sdi;
			cmd_ff         <= bypass_mode.enable & bypass_mode.second & p.byp_cmd;
		end
	end

	assign host_data_bus_o    = hdata_o_ff;
	assign host_irq           = irq_ff;
	assign host_sync_out      = sync_out_ff;
	assign bypass_cs_pullup_en = pullup_ff;
	assign bypass_pulldown_en = pulldown_ff;
	assign reg_index          = reg_index_ff;
	assign reg_wr_pulse       = reg_wr_pulse_ff;
	assign reg_wr_data        = reg_wr_data_ff;
	assign reg_rd_pulse       = reg_rd_pulse_ff;
	assign panel_frame_pin    = frame_ff;
	assign panel_line_pin     = line_ff;
	assign panel_data_pins_o  = pdata_o_ff;
	assign panel_data_pins_oe = rst_n & ~byp_rd_ff;
	assign first_panel_cs_n   = first_cs_n_ff;
	assign second_panel_cs_n  = second_cs_n_ff;
	assign second_panel_sck   = sck_ff;
	assign second_panel_sdo   = sdo_ff;
	assign second_panel_cmd   = cmd_ff;

	sequence s_write_release;
		(st_ff == ihpi_pkg::IHPI_WRITE) && !wr_req;
	endsequence

	sequence s_access_start;
		(st_ff == ihpi_pkg::IHPI_IDLE) && (rd_req || wr_req);
	endsequence

	// Outputs are checked one edge after reset is sampled, once the flops have taken it
	a_bus_released_reset: assert property (@(posedge clk) disable iff (1'b0)
		!rst_n |=> !host_data_bus_oe && !host_irq)
		else $error("host bus or interrupt active in reset");
	a_drive_only_read: assert property (@(posedge clk) disable iff (!rst_n)
		host_data_bus_oe && !byp_rd_ff |-> $past(rd_req))
		else $error("host bus driven without a selected read");
	a_index_latched: assert property (@(posedge clk) disable iff (!rst_n)
		s_access_start |=> reg_index == $past(p.index))
		else $error("port index not latched at access start");
	a_write_commit: assert property (@(posedge clk) disable iff (!rst_n)
		s_write_release |=> reg_wr_pulse ##1 !reg_wr_pulse)
		else $error("write release did not give one pulse");
	a_style68_read: assert property (@(posedge clk) disable iff (!rst_n)
		strap_ff && strap_taken_ff && st_ff == ihpi_pkg::IHPI_IDLE && !p.cs_n
		&& !p.rd_pin && p.wr_pin |=> st_ff == ihpi_pkg::IHPI_READ && reg_rd_pulse)
		else $error("68-style read not decoded");
	a_style80_write: assert property (@(posedge clk) disable iff (!rst_n)
		!strap_ff && strap_taken_ff && st_ff == ihpi_pkg::IHPI_IDLE && !p.cs_n
		&& p.rd_pin && !p.wr_pin |=> st_ff == ihpi_pkg::IHPI_WRITE)
		else $error("80-style write not decoded");
	a_irq_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		irq_event |=> host_irq)
		else $error("interrupt event lost");
	a_irq_clears: assert property (@(posedge clk) disable iff (!rst_n)
		host_irq && irq_clear && !irq_event |=> !host_irq)
		else $error("interrupt not cleared");
	a_sync_follows: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |=> host_sync_out == ($past(sync_cfg[ihpi_pkg::IHPI_SYNC_EN_BIT])
		& ($past(frame_sync) ^ $past(sync_cfg[ihpi_pkg::IHPI_SYNC_INV_BIT]))))
		else $error("sync output wrong");
	a_pulls_follow: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |=> bypass_pulldown_en == $past(misc_cfg[ihpi_pkg::IHPI_PULL_CTRL_BIT])
		&& bypass_cs_pullup_en == bypass_pulldown_en)
		else $error("pull enable does not follow control bit");
	a_frame_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		par_byp |=> panel_frame_pin == $past(p.wr_pin) && panel_line_pin == $past(p.byp_cmd))
		else $error("parallel bypass strobe or command not passed");
	a_serial_bypass: assert property (@(posedge clk) disable iff (!rst_n)
		ser_byp |=> second_panel_sck == $past(p.byp_sck) && second_panel_sdo == $past(p.byp_sdi))
		else $error("serial bypass clock or data not passed");

endmodule

// File: src/ihpi_pkg.sv
package ihpi_pkg;

	// Every host-side and bypass pin, as seen after the input synchroniser
	typedef struct packed {
		logic        cs_n;
		logic        rd_pin;
		logic        wr_pin;
		logic [2:0]  index;
		logic        strap;
		logic        byp_cs_n;
		logic        byp_sck;
		logic        byp_sdi;
		logic        byp_cmd;
		logic [15:0] hdata;
		logic [15:0] pdata;
	} ihpi_pins_t;

	localparam int IHPI_PINS_W = $bits(ihpi_pins_t);

	// Idle pin levels: strobes and chip selects high, everything else low, command select included
	localparam ihpi_pins_t IHPI_PINS_RST = '{
		cs_n:     1'b1,
		rd_pin:   1'b1,
		wr_pin:   1'b1,
		index:    3'h0,
		strap:    1'b0,
		byp_cs_n: 1'b1,
		byp_sck:  1'b0,
		byp_sdi:  1'b0,
		byp_cmd:  1'b0,
		hdata:    16'h0000,
		pdata:    16'h0000
	};

	typedef struct packed {
		logic enable;
		logic serial;
		logic second;
	} ihpi_bypass_t;

	localparam logic [15:0] IHPI_MISC_CFG_ADDR = 16'h0014;
	localparam logic [15:0] IHPI_SYNC_CFG_ADDR = 16'h0198;
	localparam int          IHPI_PULL_CTRL_BIT = 4;
	localparam int          IHPI_SYNC_EN_BIT   = 0;
	localparam int          IHPI_SYNC_INV_BIT  = 1;
	localparam int          IHPI_STRAP_WAIT    = 4;

	localparam logic        IHPI_STYLE_80      = 1'b0;
	localparam logic        IHPI_STYLE_68      = 1'b1;
	localparam logic        IHPI_PULL_RST      = 1'b1;
	localparam logic        IHPI_CS_OFF        = 1'b1;
	localparam logic [15:0] IHPI_DATA_RST      = 16'h0000;
	localparam logic [2:0]  IHPI_INDEX_RST     = 3'h0;

	typedef enum logic [2:0] {
		IHPI_IDLE  = 3'h1,
		IHPI_READ  = 3'h2,
		IHPI_WRITE = 3'h4
	} ihpi_state_t;

endpackage

// File: src/ihpi_pin_sync.sv
`timescale 1ns/1ns
module ihpi_pin_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] q_ff
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// A bit moves only once two stages agree, which also rejects a one-cycle glitch
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					q_ff[i] <= RST_VAL[i];
				end else if (s2_ff[i] == s3_ff[i]) begin
					q_ff[i] <= s3_ff[i];
				end
			end
		end
	endgenerate

endmodule

// File: verification/ihpi_host_bfm.sv
`timescale 1ns/1ns
module ihpi_host_bfm (
	input  wire logic        clk,
	input  wire logic        dev_oe,
	input  wire logic [15:0] dev_d,
	output logic             cs_n,
	output logic             rd_pin,
	output logic             wr_pin,
	output logic [2:0]       index,
	output logic [15:0]      bus
);
	logic [15:0] drv = 16'h0000;
	logic        drv_en = 1'b0;
	initial begin
		cs_n = 1'b1;
		rd_pin = 1'b1;
		wr_pin = 1'b1;
		index = 3'h0;
	end
	// No pull on the bus: once released it shows the inverse of the last value
	assign bus = dev_oe ? dev_d : (drv_en ? drv : ~drv);
	task automatic drive(input logic c, input logic r, input logic w, input logic [2:0] i,
		input logic [15:0] d, input logic e);
		@(posedge clk);
		cs_n   <= c;
		rd_pin <= r;
		wr_pin <= w;
		index  <= i;
		drv    <= d;
		drv_en <= e;
	endtask
	// Strobe held seven cycles so the input synchroniser cannot filter it
	task automatic write(input logic [2:0] i, input logic [15:0] d, input logic style);
		drive(1'b0, ~style, 1'b0, i, d, 1'b1);
		repeat (6) @(posedge clk);
		drive(1'b1, 1'b1, 1'b1, i, d, 1'b0);
		// Pulse lands five edges after release; the margin lets its counter settle
		repeat (8) @(posedge clk);
	endtask
	task automatic read(input logic [2:0] i, output logic [15:0] d, output logic ok);
		int n;
		drive(1'b0, 1'b0, 1'b1, i, drv, 1'b0);
		n = 0;
		ok = 1'b0;
		while (n < 20 && !ok) begin
			@(posedge clk);
			ok = (dev_oe === 1'b1);
			n++;
		end
		repeat (2) @(posedge clk);
		d = bus;
		drive(1'b1, 1'b1, 1'b1, i, drv, 1'b0);
		repeat (6) @(posedge clk);
	endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   strap = 1'b0;
	logic                   cs_n, rd_pin, wr_pin, hoe, irq, sync_o, pu, pd, poe;
	logic [2:0]             idx, reg_index;
	logic [15:0]            hbus, ho, po, pi, wr_data;
	logic [15:0]            pnl_drv = 16'h0000;
	logic                   byp_cs_n = 1'b1, byp_sck = 1'b0, byp_sdi = 1'b0, byp_cmd = 1'b0;
	logic [15:0]            misc_cfg = 16'h0010, sync_cfg = 16'h0000, rd_data = 16'h0000;
	ihpi_pkg::ihpi_bypass_t byp_mode = '{1'b0, 1'b0, 1'b0};
	logic                   irq_event = 1'b0, irq_clear = 1'b0, frame_sync = 1'b0;
	logic                   wr_pulse, rd_pulse, pframe, pline, cs1_n, cs2_n, sck2, sdo2, cmd2;
	logic [15:0]            d;
	logic                   ok;
	int                     bad_count = 0, compares = 0, wr_cnt = 0, rd_cnt = 0;
	logic [2:0]             wr_idx, rd_idx;
	logic [15:0]            wr_dat;

	initial forever #20 clk = ~clk;
	assign pi = poe ? po : pnl_drv;

	ihpi_host_bfm host (.clk(clk), .dev_oe(hoe), .dev_d(ho), .cs_n(cs_n), .rd_pin(rd_pin),
		.wr_pin(wr_pin), .index(idx), .bus(hbus));

	ihpi_host_pins uut (.clk(clk), .rst_n(rst_n), .host_port_index(idx), .host_cs_n(cs_n),
		.host_rd_pin(rd_pin), .host_wr_pin(wr_pin), .bus_style_strap(strap),
		.host_data_bus_i(hbus), .host_data_bus_o(ho), .host_data_bus_oe(hoe),
		.host_irq(irq), .host_sync_out(sync_o), .bypass_chip_select_n(byp_cs_n),
		.bypass_sck(byp_sck), .bypass_sdi(byp_sdi), .bypass_cmd_select(byp_cmd),
		.bypass_cs_pullup_en(pu), .bypass_pulldown_en(pd), .misc_cfg(misc_cfg),
		.sync_cfg(sync_cfg), .bypass_mode(byp_mode), .irq_event(irq_event),
		.irq_clear(irq_clear), .frame_sync(frame_sync), .reg_index(reg_index),
		.reg_wr_pulse(wr_pulse), .reg_wr_data(wr_data), .reg_rd_pulse(rd_pulse),
		.reg_rd_data(rd_data), .normal_frame(1'b1), .normal_line(1'b1),
		.normal_pdata(16'h0F0F), .panel_frame_pin(pframe), .panel_line_pin(pline),
		.panel_data_pins_i(pi), .panel_data_pins_o(po), .panel_data_pins_oe(poe),
		.first_panel_cs_n(cs1_n), .second_panel_cs_n(cs2_n), .second_panel_sck(sck2),
		.second_panel_sdo(sdo2), .second_panel_cmd(cmd2));

	// Pulses last one cycle, so they are caught here rather than by the tasks
	always @(posedge clk) begin
		if (wr_pulse === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wr_idx <= reg_index;
			wr_dat <= wr_data;
		end
		if (rd_pulse === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
			rd_idx <= reg_index;
		end
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			bad_count++;
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic s);
		chk(n, {15'h0000, e}, {15'h0000, s});
	endtask
	// Pin paths run through a four-flop synchroniser plus an output flop
	task automatic settle;
		repeat (12) @(posedge clk);
	endtask
	task automatic do_reset(input logic s);
		rst_n <= 1'b0;
		strap <= s;
		irq_event <= 1'b1;
		frame_sync <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk1("host_oe", 1'b0, hoe);
		chk1("irq", 1'b0, irq);
		chk1("sync", 1'b0, sync_o);
		chk1("panel_oe", 1'b0, poe);
		chk1("cs1", 1'b1, cs1_n);
		chk1("cs2", 1'b1, cs2_n);
		chk1("pullup", 1'b1, pu);
		chk1("pulldown", 1'b1, pd);
		// Event inputs drop one edge before release so no set is pending at release
		@(posedge clk);
		irq_event <= 1'b0;
		frame_sync <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		irq_clear <= 1'b1;
		@(posedge clk);
		irq_clear <= 1'b0;
	endtask
	task automatic host_rw(input logic style, input logic [2:0] i, input logic [15:0] v);
		int w0, r0;
		w0 = wr_cnt;
		r0 = rd_cnt;
		host.write(i, v, style);
		chk("wr_count", 16'(w0 + 1), 16'(wr_cnt));
		chk("wr_index", {13'h0000, i}, {13'h0000, wr_idx});
		chk("wr_data", v, wr_dat);
		rd_data <= ~v;
		host.read(~i, d, ok);
		chk1("rd_answer", 1'b1, ok);
		chk("rd_data", ~v, d);
		chk("rd_count", 16'(r0 + 1), 16'(rd_cnt));
		chk("rd_index", {13'h0000, ~i}, {13'h0000, rd_idx});
		chk1("oe_after_rd", 1'b0, hoe);
	endtask
	task automatic test_done;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		test_done;
	end

	initial begin
		do_reset(1'b0);
		for (int i = 0; i < 8; i++) begin
			host_rw(1'b0, 3'(i), 16'hA5C0 | 16'(i));
		end
		host.drive(1'b1, 1'b0, 1'b0, 3'h1, 16'h0000, 1'b1);
		settle;
		chk1("oe_no_cs", 1'b0, hoe);
		host.drive(1'b1, 1'b1, 1'b1, 3'h1, 16'h0000, 1'b0);
		settle;
		chk("no_cs_count", 16'(8), 16'(wr_cnt + rd_cnt - 8));
		irq_event <= 1'b1;
		@(posedge clk);
		irq_event <= 1'b0;
		repeat (2) @(posedge clk);
		chk1("irq_set", 1'b1, irq);
		irq_clear <= 1'b1;
		@(posedge clk);
		irq_clear <= 1'b0;
		repeat (2) @(posedge clk);
		chk1("irq_clr", 1'b0, irq);
		sync_cfg <= 16'h0001;
		frame_sync <= 1'b1;
		settle;
		chk1("sync_on", 1'b1, sync_o);
		frame_sync <= 1'b0;
		settle;
		chk1("sync_off", 1'b0, sync_o);
		sync_cfg <= 16'h0003;
		settle;
		chk1("sync_inv", 1'b1, sync_o);
		misc_cfg <= 16'hFFEF;
		settle;
		chk1("pullup_off", 1'b0, pu);
		chk1("pulldown_off", 1'b0, pd);
		misc_cfg <= 16'h0010;
		settle;
		chk1("pullup_on", 1'b1, pu);
		chk1("pulldown_on", 1'b1, pd);
		byp_mode <= '{1'b1, 1'b0, 1'b0};
		byp_cs_n <= 1'b0;
		byp_cmd <= 1'b1;
		host.drive(1'b1, 1'b1, 1'b0, 3'h0, 16'hC3A5, 1'b1);
		settle;
		chk1("cs1_byp", 1'b0, cs1_n);
		chk1("cs2_idle", 1'b1, cs2_n);
		chk1("frame_pin", 1'b0, pframe);
		chk1("line_pin", 1'b1, pline);
		chk("panel_out", 16'hC3A5, po);
		chk1("panel_oe", 1'b1, poe);
		pnl_drv <= 16'h5A5A;
		host.drive(1'b1, 1'b0, 1'b1, 3'h0, 16'h0000, 1'b0);
		settle;
		chk1("frame_hi", 1'b1, pframe);
		chk1("byp_rd_oe", 1'b1, hoe);
		chk("byp_rd_data", 16'h5A5A, hbus);
		chk1("byp_rd_poe", 1'b0, poe);
		host.drive(1'b1, 1'b1, 1'b1, 3'h0, 16'h0000, 1'b0);
		byp_mode <= '{1'b1, 1'b1, 1'b1};
		byp_sck <= 1'b1;
		byp_sdi <= 1'b1;
		settle;
		chk1("cs2_ser", 1'b0, cs2_n);
		chk1("sck2_hi", 1'b1, sck2);
		chk1("sdo2_hi", 1'b1, sdo2);
		chk1("cmd2_hi", 1'b1, cmd2);
		byp_sck <= 1'b0;
		byp_sdi <= 1'b0;
		byp_cmd <= 1'b0;
		byp_cs_n <= 1'b1;
		settle;
		chk1("sck2_lo", 1'b0, sck2);
		chk1("sdo2_lo", 1'b0, sdo2);
		chk1("cmd2_lo", 1'b0, cmd2);
		chk1("cs2_off", 1'b1, cs2_n);
		byp_mode <= '{1'b0, 1'b0, 1'b0};
		do_reset(1'b1);
		host_rw(1'b1, 3'h7, 16'h5AA5);
		host_rw(1'b1, 3'h0, 16'h8001);
		test_done;
	end
endmodule
